// ===== hdl/etic_skid.sv
`timescale 1ns/1ps
`default_nettype none
module etic_skid
  import etic_pkg::*;
#(
  parameter int WIDTH = $bits(etic_entry_type)
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  // Level
  output logic full_o
);

  logic [1:0] count;
  logic [WIDTH-1:0] tail;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign full_o = (count == 2'h2);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      count <= 2'h0;
    else if (push && !pop)
      count <= count + 2'h1;
    else if (pop && !push)
      count <= count - 2'h1;
  end

  // The head always holds the oldest word, so the output is a flop.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      out_data_o <= '0;
      tail <= '0;
    end
    else
    begin
      if (pop)
        out_data_o <= (count == 2'h2) ? tail : in_data_i;
      else if (push && count == 2'h0)
        out_data_o <= in_data_i;
      if (push && count == 2'h1 && !pop)
        tail <= in_data_i;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/etic_top.sv
`timescale 1ns/1ps
`default_nettype none
module etic_top
  import etic_pkg::*;
#(
  parameter int P_DELAY_CYC_1 = DELAY_CYC_1,
  parameter int P_DELAY_CYC_2 = DELAY_CYC_2,
  parameter int P_DELAY_CYC_3 = DELAY_CYC_3,
  parameter int P_DELAY_CYC_4 = DELAY_CYC_4,
  parameter int P_DELAY_CYC_5 = DELAY_CYC_5
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Sensor lines from the pins
  input wire logic [CHANNELS-1:0] sensor_line_i,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
  // AXI4-Lite read data
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // Filtered levels
  output logic [CHANNELS-1:0] filtered_line_o
);

  // ****************************************************************
  // Configuration state
  // ****************************************************************
  logic [2:0] delay_code [CHANNELS];
  logic [CHANNELS-1:0] rise_en;
  logic [CHANNELS-1:0] fall_en;
  logic freeze;

  function automatic logic [DELAY_CNT_W-1:0] delay_limit(input logic [2:0] code);
    logic [DELAY_CNT_W-1:0] lim;
    case (code)
      3'h0: lim = '0;
      3'h1: lim = DELAY_CNT_W'(P_DELAY_CYC_1);
      3'h3: lim = DELAY_CNT_W'(P_DELAY_CYC_3);
      3'h4: lim = DELAY_CNT_W'(P_DELAY_CYC_4);
      3'h5: lim = DELAY_CNT_W'(P_DELAY_CYC_5);
      default: lim = DELAY_CNT_W'(P_DELAY_CYC_2);
    endcase
    return lim;
  endfunction

  function automatic logic [1:0] lowest_pending(input logic [CHANNELS-1:0] req);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = CHANNELS - 1; i >= 0; i--)
    begin
      if (req[i])
        idx = 2'(i);
    end
    return idx;
  endfunction

  function automatic logic [7:0] entry_byte(input etic_entry_type e, input logic [1:0] lane);
    logic [7:0] b;
    case (lane)
      2'h0: b = {4'h0, e.snap};
      2'h1: b = {1'b0, e.seq};
      2'h2: b = e.stamp[7:0];
      default: b = e.stamp[15:8];
    endcase
    return b;
  endfunction

  // ****************************************************************
  // Microsecond timer
  // ****************************************************************
  logic [4:0] prescale;
  logic [31:0] us_count;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      prescale <= 5'h00;
      us_count <= 32'h0000_0000;
    end
    else if (prescale == PRESCALE_LAST)
    begin
      prescale <= 5'h00;
      us_count <= us_count + 32'h0000_0001;
    end
    else
      prescale <= prescale + 5'h01;
  end

  // ****************************************************************
  // Input synchronisers and delay filters
  // ****************************************************************
  logic [CHANNELS-1:0] sync_a;
  logic [CHANNELS-1:0] sync_b;
  logic [CHANNELS-1:0] filt_d;
  wire [CHANNELS-1:0] filt;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      sync_a <= '0;
      sync_b <= '0;
      filt_d <= '0;
    end
    else
    begin
      sync_a <= sensor_line_i;
      sync_b <= sync_a;
      filt_d <= filt;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_filter
      logic [DELAY_CNT_W-1:0] cnt;
      logic level;
      wire [DELAY_CNT_W-1:0] limit = delay_limit(delay_code[ch]);
      wire differs = (sync_b[ch] != level);
      assign filt[ch] = level;
      always_ff @(posedge core_clk_i)
      begin
        if (rst_i)
        begin
          cnt <= '0;
          level <= 1'b0;
        end
        else if (!differs)
          cnt <= '0;
        else if ({1'b0, cnt} + 21'h1 >= {1'b0, limit})
        begin
          cnt <= '0;
          level <= sync_b[ch];
        end
        else
          cnt <= cnt + 20'h1;
      end
    end
  endgenerate

  assign filtered_line_o = filt;

  // ****************************************************************
  // Edge detection and per-channel pending entries
  // ****************************************************************
  // edges of filtered level
  wire [CHANNELS-1:0] rise = filt & ~filt_d;
  wire [CHANNELS-1:0] fall = ~filt & filt_d;
  wire [CHANNELS-1:0] edge_hit = (rise & rise_en) | (fall & fall_en);

  logic [CHANNELS-1:0] pend;
  logic [3:0] pend_snap [CHANNELS];
  logic [15:0] pend_stamp [CHANNELS];
  logic [6:0] seq_count;
  logic buf_in_ready;
  etic_entry_type push_entry;

  wire [1:0] grant_idx = lowest_pending(pend);
  wire push = (|pend) & buf_in_ready;

  assign push_entry = '{snap: pend_snap[grant_idx], seq: seq_count,
                        stamp: pend_stamp[grant_idx]};

  // A new edge in the cycle its channel is granted re-arms the slot.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pend <= '0;
      for (int i = 0; i < CHANNELS; i++)
      begin
        pend_snap[i] <= 4'h0;
        pend_stamp[i] <= 16'h0000;
      end
    end
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        if (edge_hit[i])
        begin
          pend[i] <= 1'b1;
          pend_snap[i] <= filt;
          pend_stamp[i] <= us_count[15:0];
        end
        else if (push && grant_idx == 2'(i))
          pend[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      seq_count <= 7'h00;
    else if (push)
      seq_count <= seq_count + 7'h01;
  end

  // ****************************************************************
  // Two-entry buffer and the stamp record
  // ****************************************************************
  logic buf_out_valid;
  logic buf_full;
  logic buf_full_d;
  etic_entry_type buf_out;
  etic_entry_type rec [ENTRIES];
  logic [3:0] rec_count;
  logic [31:0] diag_stamp;
  wire drain = buf_out_valid & ~freeze;

  etic_skid u_skid (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(|pend),
    .in_data_i(push_entry),
    .in_ready_o(buf_in_ready),
    .out_valid_o(buf_out_valid),
    .out_data_o(buf_out),
    .out_ready_i(~freeze),
    .full_o(buf_full)
  );

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rec_count <= 4'h0;
      for (int i = 0; i < ENTRIES; i++)
        rec[i] <= '0;
    end
    else if (drain)
    begin
      rec[0] <= buf_out;
      for (int i = 1; i < ENTRIES; i++)
        rec[i] <= rec[i-1];
      if (rec_count != REC_COUNT_MAX)
        rec_count <= rec_count + 4'h1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      buf_full_d <= 1'b0;
      diag_stamp <= 32'h0000_0000;
    end
    else
    begin
      buf_full_d <= buf_full;
      if (buf_full && !buf_full_d)
        diag_stamp <= us_count;
    end
  end

  // ****************************************************************
  // Diagnostic bytes
  // ****************************************************************
  wire param_err = (delay_code[0] > DELAY_CODE_MAX) | (delay_code[1] > DELAY_CODE_MAX) |
                   (delay_code[2] > DELAY_CODE_MAX) | (delay_code[3] > DELAY_CODE_MAX);
  logic [7:0] error_flags;
  logic [7:0] full_error;

  always_comb
  begin
    error_flags = 8'h00;
    error_flags[ERR_MODULE_BIT] = buf_full | param_err;
    error_flags[ERR_INTERNAL_BIT] = buf_full;
    error_flags[ERR_ANY_BIT] = buf_full | param_err;
    error_flags[ERR_PARAM_BIT] = param_err;
    full_error = 8'h00;
    full_error[FULL_ERROR_BIT] = buf_full;
  end

  // ****************************************************************
  // Read decode
  // ****************************************************************
  wire [7:0] rd_idx = s_axi_araddr_i[AXI_ADDR_W-1:2];
  wire [7:0] in_k = rd_idx - IDX_INPUT_BASE;
  wire [5:0] rd_entry = in_k[7:2];
  wire [1:0] stamp_lane = 2'(rd_idx - IDX_STAMP);
  logic [7:0] rd_byte;
  logic rd_ok;

  always_comb
  begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    if (rd_idx >= IDX_INPUT_BASE && rd_idx < IDX_INPUT_END)
    begin
      if ({2'h0, rec_count} > rd_entry)
        rd_byte = entry_byte(rec[rd_entry[3:0]], in_k[1:0]);
    end
    else if (rd_idx >= IDX_STAMP && rd_idx <= IDX_STAMP_LAST)
      rd_byte = diag_stamp[{stamp_lane, 3'h0} +: 8];
    else if (rd_idx >= IDX_CHANNEL_ERROR && rd_idx < IDX_STAMP)
      rd_byte = 8'h00;
    else if (rd_idx >= IDX_DELAY_BASE && rd_idx < IDX_DELAY_END)
      rd_byte = {5'h00, delay_code[rd_idx[1:0]]};
    else
    begin
      case (rd_idx)
        IDX_ERROR_FLAGS: rd_byte = error_flags;
        IDX_MODULE_KIND: rd_byte = MODULE_KIND_VALUE;
        IDX_SPARE_ERROR: rd_byte = 8'h00;
        IDX_FULL_ERROR: rd_byte = full_error;
        IDX_CHANNEL_KIND: rd_byte = CHANNEL_KIND_VALUE;
        IDX_DIAG_BITS: rd_byte = DIAG_BITS_PER_CHANNEL;
        IDX_CHANNEL_COUNT: rd_byte = CHANNEL_COUNT_VALUE;
        IDX_RISE_EN: rd_byte = {4'h0, rise_en};
        IDX_FALL_EN: rd_byte = {4'h0, fall_en};
        IDX_CONTROL: rd_byte = {7'h00, freeze};
        IDX_STATUS: rd_byte = {4'h0, rec_count};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic aw_held;
  logic w_held;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid_o;
  wire [7:0] wr_idx = aw_addr[AXI_ADDR_W-1:2];
  wire wr_delay = (wr_idx >= IDX_DELAY_BASE) && (wr_idx < IDX_DELAY_END);
  wire wr_ok = wr_delay | (wr_idx == IDX_RISE_EN) | (wr_idx == IDX_FALL_EN) |
               (wr_idx == IDX_CONTROL);
  wire wr_apply = wr_fire & wr_ok & w_lane0;

  assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
  assign s_axi_wready_o = ~w_held & ~s_axi_bvalid_o;
  assign s_axi_arready_o = ~s_axi_rvalid_o;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata_i[7:0];
        w_lane0 <= s_axi_wstrb_i[0];
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < CHANNELS; i++)
        delay_code[i] <= DELAY_CODE_RESET;
      rise_en <= '0;
      fall_en <= '0;
      freeze <= 1'b0;
    end
    else if (wr_apply)
    begin
      if (wr_delay)
        delay_code[wr_idx[1:0]] <= w_byte[2:0];
      if (wr_idx == IDX_RISE_EN)
        rise_en <= w_byte[CHANNELS-1:0];
      if (wr_idx == IDX_FALL_EN)
        fall_en <= w_byte[CHANNELS-1:0];
      if (wr_idx == IDX_CONTROL)
        freeze <= w_byte[CONTROL_FREEZE_BIT];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h00_0000, rd_byte};
      s_axi_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

endmodule
`default_nettype wire

// ===== shared/etic_pkg.sv
package etic_pkg;

  // ****************************************************************
  // Geometry of the block
  // ****************************************************************
  localparam int CHANNELS = 4;
  localparam int ENTRIES = 15;
  localparam logic [3:0] REC_COUNT_MAX = 4'hf;
  localparam int AXI_ADDR_W = 10;

  // ****************************************************************
  // Clock rate and filter delays
  // ****************************************************************
  localparam int CLK_KHZ = 25000;
  localparam int CYCLES_PER_US = CLK_KHZ / 1000;
  localparam logic [4:0] PRESCALE_LAST = 5'(CYCLES_PER_US - 1);
  localparam int DELAY_US_1 = 300;
  localparam int DELAY_US_2 = 3000;
  localparam int DELAY_US_3 = 10000;
  localparam int DELAY_US_4 = 20000;
  localparam int DELAY_US_5 = 40000;
  localparam int DELAY_CYC_1 = DELAY_US_1 * CYCLES_PER_US;
  localparam int DELAY_CYC_2 = DELAY_US_2 * CYCLES_PER_US;
  localparam int DELAY_CYC_3 = DELAY_US_3 * CYCLES_PER_US;
  localparam int DELAY_CYC_4 = DELAY_US_4 * CYCLES_PER_US;
  localparam int DELAY_CYC_5 = DELAY_US_5 * CYCLES_PER_US;
  localparam int DELAY_CNT_W = 20;
  localparam logic [2:0] DELAY_CODE_RESET = 3'h2;
  localparam logic [2:0] DELAY_CODE_MAX = 3'h5;

  // ****************************************************************
  // Register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] IDX_ERROR_FLAGS = 8'h00;
  localparam logic [7:0] IDX_MODULE_KIND = 8'h01;
  localparam logic [7:0] IDX_SPARE_ERROR = 8'h02;
  localparam logic [7:0] IDX_FULL_ERROR = 8'h03;
  localparam logic [7:0] IDX_CHANNEL_KIND = 8'h04;
  localparam logic [7:0] IDX_DIAG_BITS = 8'h05;
  localparam logic [7:0] IDX_CHANNEL_COUNT = 8'h06;
  localparam logic [7:0] IDX_CHANNEL_ERROR = 8'h07;
  localparam logic [7:0] IDX_STAMP = 8'h2b;
  localparam logic [7:0] IDX_STAMP_LAST = 8'h2e;
  localparam logic [7:0] IDX_INPUT_BASE = 8'h40;
  localparam logic [7:0] IDX_INPUT_END = 8'h7c;
  localparam logic [7:0] IDX_DELAY_BASE = 8'h80;
  localparam logic [7:0] IDX_DELAY_END = 8'h84;
  localparam logic [7:0] IDX_RISE_EN = 8'h84;
  localparam logic [7:0] IDX_FALL_EN = 8'h85;
  localparam logic [7:0] IDX_CONTROL = 8'h86;
  localparam logic [7:0] IDX_STATUS = 8'h87;

  // ****************************************************************
  // Field positions and fixed values
  // ****************************************************************
  localparam int ERR_MODULE_BIT = 0;
  localparam int ERR_INTERNAL_BIT = 1;
  localparam int ERR_ANY_BIT = 4;
  localparam int ERR_PARAM_BIT = 7;
  localparam int FULL_ERROR_BIT = 3;
  localparam int CONTROL_FREEZE_BIT = 0;
  localparam logic [7:0] DIAG_BITS_PER_CHANNEL = 8'h00;
  localparam logic [7:0] CHANNEL_COUNT_VALUE = 8'h08;
  // Identity values are arbitrary.
  localparam logic [7:0] MODULE_KIND_VALUE = 8'h5a;
  localparam logic [7:0] CHANNEL_KIND_VALUE = 8'h21;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] snap;
    logic [6:0] seq;
    logic [15:0] stamp;
  } etic_entry_type;

endpackage

// ===== tb/edge_timestamp_input_capture_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module edge_timestamp_input_capture_tb_top;
  import etic_pkg::*;
  logic core_clk_i = 0;
  logic rst_i = 1;
  logic [3:0] sens = 4'h0;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, filt;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  logic [7:0] lo;
  logic [15:0] t0;
  int bad_count = 0;
  int samples_checked = 0;
  int n = 0;
  localparam logic [7:0] PARAM_ERR_FLAGS =
    8'((1 << ERR_MODULE_BIT) | (1 << ERR_ANY_BIT) | (1 << ERR_PARAM_BIT));
  localparam logic [7:0] FULL_ERR_FLAGS =
    8'((1 << ERR_MODULE_BIT) | (1 << ERR_INTERNAL_BIT) | (1 << ERR_ANY_BIT));
  logic [7:0] cidx [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0b, 8'h2a,
    8'h2b, 8'h80, 8'h84, 8'h85, 8'h87, 8'h40};
  logic [7:0] cexp [15] = '{8'h0, MODULE_KIND_VALUE, 8'h0, 8'h0, CHANNEL_KIND_VALUE,
    DIAG_BITS_PER_CHANNEL, CHANNEL_COUNT_VALUE, 8'h0, 8'h0, 8'h0, 8'(DELAY_CODE_RESET),
    8'h0, 8'h0, 8'h0, 8'h0};

  always #20 core_clk_i = ~core_clk_i;

  etic_top #(.P_DELAY_CYC_1(3), .P_DELAY_CYC_2(6), .P_DELAY_CYC_3(10), .P_DELAY_CYC_4(20),
    .P_DELAY_CYC_5(40)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .sensor_line_i(sens),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .filtered_line_o(filt));

  etic_adapter_model bus (.clk_i(core_clk_i), .awvalid_o(awvalid), .awaddr_o(awaddr),
    .wvalid_o(wvalid), .wdata_o(wdata), .wstrb_o(wstrb), .bready_o(bready),
    .arvalid_o(arvalid), .araddr_o(araddr), .rready_o(rready), .awready_i(awready),
    .wready_i(wready), .bvalid_i(bvalid), .bresp_i(bresp), .arready_i(arready),
    .rvalid_i(rvalid), .rdata_i(rdata), .rresp_i(rresp));

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] re);
    bus.rd(idx, d, r);
    chk("read", {re, 24'h0, e}, {r, d});
  endtask

  task automatic wchk(input logic [7:0] idx, input logic [7:0] v, input logic [1:0] re);
    bus.wr(idx, {24'h0, v}, r);
    chk("bresp", {32'h0, re}, {32'h0, r});
  endtask

  task automatic tog(input logic [3:0] m, input int w);
    @(posedge core_clk_i);
    sens <= sens ^ m;
    repeat (w) @(posedge core_clk_i);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 15; i++)
      rchk(cidx[i], cexp[i], RESP_OKAY);
    rchk(8'h3f, 8'h0, RESP_SLVERR);
    wchk(IDX_CHANNEL_COUNT, 8'h0, RESP_SLVERR);
    rchk(IDX_CHANNEL_COUNT, CHANNEL_COUNT_VALUE, RESP_OKAY);
    $display("registers test done");
    for (int c = 0; c <= 5; c++)
    begin
      wchk(IDX_DELAY_BASE, 8'(c), RESP_OKAY);
      rchk(IDX_DELAY_BASE, 8'(c), RESP_OKAY);
    end
    wchk(IDX_DELAY_BASE + 8'h3, 8'h6, RESP_OKAY);
    rchk(IDX_ERROR_FLAGS, PARAM_ERR_FLAGS, RESP_OKAY);
    wchk(IDX_RISE_EN, 8'h3, RESP_OKAY);
    wchk(IDX_FALL_EN, 8'h3, RESP_OKAY);
    tog(4'h1, 10);
    tog(4'h1, 90);
    rchk(IDX_STATUS, 8'h0, RESP_OKAY);
    for (int c = 0; c < 4; c++)
      wchk(IDX_DELAY_BASE + 8'(c), 8'h0, RESP_OKAY);
    $display("delay test done");
    tog(4'h1, 249);
    tog(4'h2, 30);
    rchk(IDX_STATUS, 8'h2, RESP_OKAY);
    rchk(8'h40, 8'h3, RESP_OKAY);
    rchk(8'h41, 8'h1, RESP_OKAY);
    rchk(8'h44, 8'h1, RESP_OKAY);
    rchk(8'h45, 8'h0, RESP_OKAY);
    bus.rd(8'h46, d, r);
    lo = d[7:0];
    bus.rd(8'h47, d, r);
    t0 = bus.word(lo, d[7:0]);
    bus.rd(8'h42, d, r);
    lo = d[7:0];
    bus.rd(8'h43, d, r);
    chk("timer", 34'd10, {18'h0, bus.word(lo, d[7:0]) - t0});
    tog(4'h4, 30);
    rchk(IDX_STATUS, 8'h2, RESP_OKAY);
    tog(4'h1, 30);
    rchk(8'h40, 8'h6, RESP_OKAY);
    chk("filtered", 34'h6, {30'h0, filt});
    n = 3;
    $display("entry test done");
    for (int i = 0; i < 127; i++)
      tog(4'h1, 20);
    n += 127;
    rchk(IDX_STATUS, 8'hf, RESP_OKAY);
    rchk(8'h41, 8'((n - 1) % 128), RESP_OKAY);
    rchk(8'h79, 8'((n - 15) % 128), RESP_OKAY);
    tog(4'h3, 30);
    n += 2;
    rchk(8'h41, 8'((n - 1) % 128), RESP_OKAY);
    rchk(8'h45, 8'((n - 2) % 128), RESP_OKAY);
    rchk(8'h40, 8'h4, RESP_OKAY);
    $display("wrap test done");
    wchk(IDX_CONTROL, 8'h1, RESP_OKAY);
    for (int i = 0; i < 3; i++)
      tog(4'h1, 20);
    rchk(IDX_FULL_ERROR, 8'h08, RESP_OKAY);
    rchk(IDX_ERROR_FLAGS, FULL_ERR_FLAGS, RESP_OKAY);
    bus.rd(IDX_STAMP, d, r);
    chk("stamp resp", {32'h0, RESP_OKAY}, {32'h0, r});
    lo = d[7:0];
    bus.rd(IDX_STAMP + 8'h1, d, r);
    t0 = bus.word(lo, d[7:0]);
    wchk(IDX_CONTROL, 8'h0, RESP_OKAY);
    repeat (30) @(posedge core_clk_i);
    n += 3;
    rchk(IDX_FULL_ERROR, 8'h0, RESP_OKAY);
    rchk(8'h41, 8'((n - 1) % 128), RESP_OKAY);
    bus.rd(8'h46, d, r);
    lo = d[7:0];
    bus.rd(8'h47, d, r);
    chk("stamp", 34'h0, {33'h0, (t0 - bus.word(lo, d[7:0])) > 16'h1});
    $display("buffer test done");
    summarize();
  end

  initial
  begin
    #(40 * 60000);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire

// ===== tb/etic_adapter_model.sv
`timescale 1ns/1ps
`default_nettype none
module etic_adapter_model
(
  // Clock
  input wire logic clk_i,
  // Requests
  output logic awvalid_o,
  output logic [9:0] awaddr_o,
  output logic wvalid_o,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic bready_o,
  output logic arvalid_o,
  output logic [9:0] araddr_o,
  output logic rready_o,
  // Answers
  input wire logic awready_i,
  input wire logic wready_i,
  input wire logic bvalid_i,
  input wire logic [1:0] bresp_i,
  input wire logic arready_i,
  input wire logic rvalid_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i
);
  initial
  begin
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h0;
    {awaddr_o, araddr_o, wdata_o, wstrb_o} = '0;
  end

  // Released address and data payloads are inverted so stale values never look valid.
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
    bit a;
    bit w;
    a = 0;
    w = 0;
    @(posedge clk_i);
    awvalid_o <= 1'b1;
    awaddr_o <= {idx, 2'h0};
    wvalid_o <= 1'b1;
    wdata_o <= d;
    wstrb_o <= 4'hf;
    bready_o <= 1'b1;
    while (!(a && w))
    begin
      @(posedge clk_i);
      if (awready_i && !a)
      begin
        a = 1;
        awvalid_o <= 1'b0;
        awaddr_o <= ~awaddr_o;
      end
      if (wready_i && !w)
      begin
        w = 1;
        wvalid_o <= 1'b0;
        wdata_o <= ~wdata_o;
      end
    end
    do @(posedge clk_i); while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    arvalid_o <= 1'b1;
    araddr_o <= {idx, 2'h0};
    rready_o <= 1'b1;
    do @(posedge clk_i); while (!arready_i);
    arvalid_o <= 1'b0;
    araddr_o <= ~araddr_o;
    do @(posedge clk_i); while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask

  function automatic logic [15:0] word(input logic [7:0] lo, input logic [7:0] hi);
    return {hi, lo};
  endfunction
endmodule
`default_nettype wire

// ===== tb/etic_checker.sv
`timescale 1ns/1ps
`default_nettype none
module etic_checker
  import etic_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Bus inputs
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_rready_i,
  // Bus outputs
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  // Filtered levels
  input wire logic [CHANNELS-1:0] filtered_line_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // ****************************************************************
  // Bus answers
  // ****************************************************************
  a_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp dropped early");
  a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("rdata dropped early");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o) else $error("read answer late");
  a_write_answer: assert property (!s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o
    |=> s_axi_bvalid_o) else $error("write answer late");
  a_write_busy: assert property (s_axi_bvalid_o
    |-> !s_axi_awready_o && !s_axi_wready_o) else $error("write taken while busy");
  a_read_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while busy");
  a_refused_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR
    |-> s_axi_rdata_o == 32'h0) else $error("refused read with data");
  a_byte_lane: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_reset_idle: assert property (disable iff (1'b0) rst_i |=> !s_axi_bvalid_o
    && !s_axi_rvalid_o && filtered_line_o == 4'h0) else $error("not idle after reset");
endmodule

bind etic_top etic_checker chk (.core_clk_i, .rst_i, .s_axi_bready_i, .s_axi_arvalid_i,
  .s_axi_rready_i, .s_axi_awready_o, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bresp_o,
  .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rdata_o, .s_axi_rresp_o, .filtered_line_o);
`default_nettype wire
